/* rtl/ecd_pkg.sv */
package ecd_pkg;

  // ********************************************************************
  // Opcode fields
  // ********************************************************************
  localparam int unsigned CLASS_MSB     = 7;
  localparam int unsigned CLASS_LSB     = 5;
  localparam int unsigned FUNC_MSB      = 4;
  localparam int unsigned FUNC_LSB      = 2;
  localparam int unsigned REG_MSB       = 1;
  localparam int unsigned REG_LSB       = 0;

  // ********************************************************************
  // Operand byte and address fields
  // ********************************************************************
  localparam int unsigned IND_BIT       = 7;
  localparam int unsigned IDXC_MSB      = 6;
  localparam int unsigned IDXC_LSB      = 5;
  localparam int unsigned PAGE_MSB      = 14;
  localparam int unsigned PAGE_LSB      = 13;
  localparam int unsigned OFFS_MSB      = 12;

  // ********************************************************************
  // Constants
  // ********************************************************************
  localparam logic [1:0] COND_ALWAYS    = 2'h3;
  localparam logic [1:0] JUMP_IDX_REG   = 2'h3;
  localparam logic [1:0] DEST_IDX_REG   = 2'h0;
  localparam logic [1:0] IDX_NONE       = 2'h0;
  localparam logic [1:0] IDX_INC        = 2'h1;
  localparam logic [1:0] IDX_DEC        = 2'h2;
  localparam logic [1:0] IDX_PLAIN      = 2'h3;
  localparam logic [7:0] OP_HALT        = 8'h40;
  localparam logic [7:0] OP_NOP         = 8'hc0;
  localparam logic [7:0] OP_ZP_JUMP     = 8'h9b;
  localparam logic [7:0] OP_ZP_CALL     = 8'hbb;
  localparam logic [7:0] OP_IDX_JUMP    = 8'h9f;
  localparam logic [7:0] OP_IDX_CALL    = 8'hbf;
  localparam logic [1:0] LEN_ONE        = 2'h1;
  localparam logic [1:0] LEN_TWO        = 2'h2;
  localparam logic [1:0] LEN_THREE      = 2'h3;
  localparam logic [14:0] RESET_PC      = 15'h0000;

  // ********************************************************************
  // Operation codes
  // ********************************************************************
  typedef enum logic [5:0] {
    OPC_LOAD, OPC_XOR, OPC_AND, OPC_OR, OPC_ADD, OPC_SUB, OPC_STORE, OPC_COMPARE,
    OPC_JUMP_T, OPC_CALL_T, OPC_JUMP_NZ, OPC_CALL_NZ, OPC_JUMP_F, OPC_CALL_F,
    OPC_JUMP_INC, OPC_JUMP_DEC, OPC_ZP_JUMP, OPC_ZP_CALL, OPC_IDX_JUMP, OPC_IDX_CALL,
    OPC_RETURN, OPC_RETURN_EI, OPC_HALT, OPC_NOP, OPC_ROT_L, OPC_ROT_R, OPC_DEC_ADJ,
    OPC_LOAD_PSU, OPC_LOAD_PSL, OPC_STORE_PSU, OPC_STORE_PSL,
    OPC_CLR_PSU, OPC_CLR_PSL, OPC_SET_PSU, OPC_SET_PSL, OPC_TST_PSU, OPC_TST_PSL,
    OPC_MASK_TEST, OPC_RD_CTRL, OPC_RD_DATA, OPC_RD_EXT, OPC_WR_CTRL, OPC_WR_DATA,
    OPC_WR_EXT, OPC_UNDEF
  } ecd_op_e;

  typedef enum logic [1:0] {
    MODE_NONE, MODE_IMM, MODE_REL, MODE_ABS
  } ecd_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_OPND1 = 3'b001,
    ST_OPND2 = 3'b011,
    ST_ISSUE = 3'b010
  } ecd_state_e;

endpackage

/* rtl/ecd_opdec.sv */
`timescale 1ns/10ps
module ecd_opdec (
  // Opcode in
  input  wire logic [7:0]      opcode,
  // Decode out
  output ecd_pkg::ecd_op_e     op,
  output ecd_pkg::ecd_mode_e   mode,
  output logic [1:0]           len,
  output logic                 cond_is_mask,
  output logic                 indexable
);
  logic [2:0] cls;
  logic [2:0] fn;
  always_comb begin
    cls          = opcode[ecd_pkg::CLASS_MSB:ecd_pkg::CLASS_LSB];
    fn           = opcode[ecd_pkg::FUNC_MSB:ecd_pkg::FUNC_LSB];
    op           = ecd_pkg::OPC_UNDEF;
    mode         = ecd_pkg::MODE_NONE;
    cond_is_mask = 1'b0;
    indexable    = 1'b0;
    // Arithmetic groups: top three bits pick the function
    unique case (fn[1:0])
      2'h0: mode = ecd_pkg::MODE_NONE;
      2'h1: mode = ecd_pkg::MODE_IMM;
      2'h2: mode = ecd_pkg::MODE_REL;
      2'h3: mode = ecd_pkg::MODE_ABS;
    endcase
    op = ecd_pkg::ecd_op_e'({3'h0, cls});
    // Only absolute memory forms take an index
    indexable = (fn[1:0] == 2'h3);
    if (fn[2] == 1'b1) begin
      indexable = 1'b0;
      mode      = (fn[1:0] == 2'h3) ? ecd_pkg::MODE_ABS : ecd_pkg::MODE_REL;
      unique case ({cls, fn[1:0]})
        5'b000_10, 5'b000_11: op = ecd_pkg::OPC_JUMP_T;
        5'b001_10, 5'b001_11: op = ecd_pkg::OPC_CALL_T;
        5'b010_10, 5'b010_11: op = ecd_pkg::OPC_JUMP_NZ;
        5'b011_10, 5'b011_11: op = ecd_pkg::OPC_CALL_NZ;
        5'b100_10, 5'b100_11: op = ecd_pkg::OPC_JUMP_F;
        5'b101_10, 5'b101_11: op = ecd_pkg::OPC_CALL_F;
        5'b110_10, 5'b110_11: op = ecd_pkg::OPC_JUMP_INC;
        5'b111_10, 5'b111_11: op = ecd_pkg::OPC_JUMP_DEC;
        default: op = ecd_pkg::OPC_UNDEF;
      endcase
      cond_is_mask = (cls == 3'h0) || (cls == 3'h1) || (cls == 3'h4) || (cls == 3'h5);
      // Control groups sit on the register and immediate codes of the branch half
      unique case (fn[1:0])
        2'h0: begin
          mode         = ecd_pkg::MODE_NONE;
          cond_is_mask = 1'b0;
          unique case (cls)
            3'h0: op = ecd_pkg::OPC_UNDEF;
            3'h1: op = ecd_pkg::OPC_RD_CTRL;
            3'h2: op = ecd_pkg::OPC_ROT_R;
            3'h3: op = ecd_pkg::OPC_RD_DATA;
            3'h4: op = opcode[0] ? ecd_pkg::OPC_LOAD_PSL : ecd_pkg::OPC_LOAD_PSU;
            3'h5: op = ecd_pkg::OPC_WR_CTRL;
            3'h6: op = ecd_pkg::OPC_ROT_L;
            3'h7: op = ecd_pkg::OPC_WR_DATA;
          endcase
        end
        2'h1: begin
          mode = ecd_pkg::MODE_NONE;
          unique case (cls)
            3'h0: op = ecd_pkg::OPC_RETURN;
            3'h1: op = ecd_pkg::OPC_RETURN_EI;
            3'h2: op = ecd_pkg::OPC_RD_EXT;
            3'h3: op = (opcode[1]) ? (opcode[0] ? ecd_pkg::OPC_SET_PSL : ecd_pkg::OPC_SET_PSU)
                                   : (opcode[0] ? ecd_pkg::OPC_CLR_PSL : ecd_pkg::OPC_CLR_PSU);
            3'h4: op = ecd_pkg::OPC_DEC_ADJ;
            3'h5: op = opcode[1] ? ecd_pkg::OPC_UNDEF
                                 : (opcode[0] ? ecd_pkg::OPC_TST_PSL : ecd_pkg::OPC_TST_PSU);
            3'h6: op = ecd_pkg::OPC_WR_EXT;
            3'h7: op = ecd_pkg::OPC_MASK_TEST;
          endcase
          if (cls == 3'h2 || cls == 3'h3 || cls == 3'h5 || cls == 3'h6 || cls == 3'h7) begin
            mode = ecd_pkg::MODE_IMM;
          end
          cond_is_mask = (cls == 3'h0) || (cls == 3'h1);
        end
        default: ;
      endcase
    end
    // Specific one-off codes
    unique case (opcode)
      8'h00: op = ecd_pkg::OPC_LOAD;
      8'h10, 8'h11: op = ecd_pkg::OPC_UNDEF;
      8'h12: op = ecd_pkg::OPC_STORE_PSU;
      8'h13: op = ecd_pkg::OPC_STORE_PSL;
      8'h20: op = ecd_pkg::OPC_XOR;
      8'h40: op = ecd_pkg::OPC_HALT;
      8'h41, 8'h42, 8'h43: op = ecd_pkg::OPC_AND;
      8'h60: op = ecd_pkg::OPC_OR;
      8'h80: op = ecd_pkg::OPC_ADD;
      8'h90, 8'h91: op = ecd_pkg::OPC_UNDEF;
      8'h9b: op = ecd_pkg::OPC_ZP_JUMP;
      8'h9f: op = ecd_pkg::OPC_IDX_JUMP;
      8'ha0: op = ecd_pkg::OPC_SUB;
      8'hb6, 8'hb7: op = ecd_pkg::OPC_UNDEF;
      8'hbb: op = ecd_pkg::OPC_ZP_CALL;
      8'hbf: op = ecd_pkg::OPC_IDX_CALL;
      8'hc0: op = ecd_pkg::OPC_NOP;
      8'hc4, 8'hc5, 8'hc6, 8'hc7: op = ecd_pkg::OPC_UNDEF;
      8'he0: op = ecd_pkg::OPC_COMPARE;
      default: ;
    endcase
    if (opcode == 8'h40 || opcode == 8'hc0 || opcode == 8'h12 || opcode == 8'h13) begin
      mode = ecd_pkg::MODE_NONE;
    end
    // Unknown codes behave as a one-byte no-op
    if (op == ecd_pkg::OPC_UNDEF) begin
      mode      = ecd_pkg::MODE_NONE;
      indexable = 1'b0;
    end
    // Length follows addressing form
    unique case (mode)
      ecd_pkg::MODE_NONE: len = ecd_pkg::LEN_ONE;
      ecd_pkg::MODE_IMM:  len = ecd_pkg::LEN_TWO;
      ecd_pkg::MODE_REL:  len = ecd_pkg::LEN_TWO;
      ecd_pkg::MODE_ABS:  len = ecd_pkg::LEN_THREE;
    endcase
  end
endmodule

/* rtl/ecd_ea.sv */
`timescale 1ns/10ps
module ecd_ea (
  // Address inputs
  input  wire logic [14:0] pc_next,
  input  wire logic [6:0]  rel_disp,
  input  wire logic [14:0] abs_base,
  input  wire logic [7:0]  index_val,
  input  wire logic        use_index,
  // Address outputs
  output logic      [14:0] rel_addr,
  output logic      [14:0] abs_addr
);
  logic [12:0] rel_low;
  logic [12:0] abs_low;
  always_comb begin
    // Sign-extend and wrap inside 8K page
    rel_low  = pc_next[ecd_pkg::OFFS_MSB:0] + {{6{rel_disp[6]}}, rel_disp};
    rel_addr = {pc_next[ecd_pkg::PAGE_MSB:ecd_pkg::PAGE_LSB], rel_low};
    // No carry into page bits
    abs_low  = abs_base[ecd_pkg::OFFS_MSB:0] + (use_index ? {5'h00, index_val} : 13'h0000);
    abs_addr = {abs_base[ecd_pkg::PAGE_MSB:ecd_pkg::PAGE_LSB], abs_low};
  end
endmodule

/* rtl/ecd_decode.sv */
`timescale 1ns/10ps
module ecd_decode (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // Program memory
  output logic      [14:0]         fetch_addr,
  output logic                     fetch_req,
  input  wire logic [7:0]          fetch_data,
  input  wire logic                fetch_valid,
  // Register file view
  input  wire logic [7:0]          index_val,
  input  wire logic [7:0]          branch_reg_val,
  input  wire logic [1:0]          cond_code,
  // Execution handshake
  input  wire logic                exec_ready,
  input  wire logic                branch_taken,
  input  wire logic [14:0]         branch_target,
  input  wire logic                resume,
  // Issued instruction
  output logic                     issue_valid,
  output ecd_pkg::ecd_op_e         issue_op,
  output logic      [2:0]          issue_func,
  output logic      [1:0]          issue_reg,
  output logic      [1:0]          issue_dest,
  output logic      [1:0]          issue_len,
  output logic      [7:0]          issue_imm,
  output logic      [14:0]         issue_ea,
  output logic                     issue_indirect,
  output logic                     issue_cond_true,
  output logic                     issue_idx_we,
  output logic      [1:0]          issue_idx_reg,
  output logic      [7:0]          issue_idx_val,
  output logic                     issue_reg_we,
  output logic      [7:0]          issue_reg_val,
  output logic                     issue_undef,
  output logic                     halted
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    ecd_pkg::ecd_state_e st;
    logic [14:0]         pc;
    logic [7:0]          opc;
    logic [7:0]          b1;
    logic [7:0]          b2;
    logic                halt;
    logic                valid;
    ecd_pkg::ecd_op_e    op;
    logic [1:0]          dest;
    logic [1:0]          len;
    logic [14:0]         ea;
    logic                ind;
    logic                ctrue;
    logic                idx_we;
    logic [1:0]          idx_reg;
    logic [7:0]          idx_val;
    logic                reg_we;
    logic [7:0]          reg_val;
  } ecd_state_s;

  ecd_state_s cur_ff;
  ecd_state_s nxt_cur;

  ecd_pkg::ecd_op_e   dec_op;
  ecd_pkg::ecd_mode_e dec_mode;
  logic [1:0]         dec_len;
  logic               dec_mask;
  logic               dec_indexable;
  logic [14:0]        rel_addr;
  logic [14:0]        abs_addr;
  logic [14:0]        abs_base;
  logic [14:0]        pc_inc;
  logic [7:0]         idx_new;
  logic [1:0]         idx_ctl;
  logic               use_idx;
  logic               is_idx_br;
  logic [7:0]         br_new;

  // ********************************************************************
  // Decode and address units
  // ********************************************************************
  ecd_opdec u_opdec (
    .opcode       (cur_ff.opc),
    .op           (dec_op),
    .mode         (dec_mode),
    .len          (dec_len),
    .cond_is_mask (dec_mask),
    .indexable    (dec_indexable)
  );

  // Memory forms stay in the current page, since b1[6:5] is index control there
  assign abs_base = dec_indexable ? {cur_ff.pc[ecd_pkg::PAGE_MSB:ecd_pkg::PAGE_LSB], cur_ff.b1[4:0], cur_ff.b2}
                                  : {cur_ff.b1[6:0], cur_ff.b2};

  ecd_ea u_ea (
    .pc_next   (cur_ff.pc),
    .rel_disp  (cur_ff.b1[6:0]),
    .abs_base  (abs_base),
    .index_val (idx_new),
    .use_index (use_idx),
    .rel_addr  (rel_addr),
    .abs_addr  (abs_addr)
  );

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    nxt_cur  = cur_ff;
    // Fetch address wraps inside page
    pc_inc   = {cur_ff.pc[ecd_pkg::PAGE_MSB:ecd_pkg::PAGE_LSB], 13'(cur_ff.pc[ecd_pkg::OFFS_MSB:0] + 13'h0001)};
    is_idx_br = (dec_op == ecd_pkg::OPC_IDX_JUMP) || (dec_op == ecd_pkg::OPC_IDX_CALL);
    idx_ctl  = cur_ff.b1[ecd_pkg::IDXC_MSB:ecd_pkg::IDXC_LSB];
    // No auto step on indexed jump or call
    use_idx  = (dec_indexable && idx_ctl != ecd_pkg::IDX_NONE) || is_idx_br;
    // Pre-step wraps modulo 256
    if (dec_indexable && idx_ctl == ecd_pkg::IDX_INC) begin
      idx_new = 8'(index_val + 8'h01);
    end else if (dec_indexable && idx_ctl == ecd_pkg::IDX_DEC) begin
      idx_new = 8'(index_val - 8'h01);
    end else begin
      idx_new = index_val;
    end
    br_new = (dec_op == ecd_pkg::OPC_JUMP_INC) ? 8'(branch_reg_val + 8'h01) : 8'(branch_reg_val - 8'h01);
    nxt_cur.valid = 1'b0;
    unique case (cur_ff.st)
      ecd_pkg::ST_IDLE: begin
        if (resume) begin
          nxt_cur.halt = 1'b0;
        end
        if (!cur_ff.halt && fetch_valid) begin
          nxt_cur.opc = fetch_data;
          nxt_cur.pc  = pc_inc;
          nxt_cur.st  = ecd_pkg::ST_OPND1;
        end
      end
      ecd_pkg::ST_OPND1: begin
        if (dec_len == ecd_pkg::LEN_ONE) begin
          nxt_cur.st = ecd_pkg::ST_ISSUE;
        end else if (fetch_valid) begin
          nxt_cur.b1 = fetch_data;
          nxt_cur.pc = pc_inc;
          nxt_cur.st = (dec_len == ecd_pkg::LEN_THREE) ? ecd_pkg::ST_OPND2 : ecd_pkg::ST_ISSUE;
        end
      end
      ecd_pkg::ST_OPND2: begin
        if (fetch_valid) begin
          nxt_cur.b2 = fetch_data;
          nxt_cur.pc = pc_inc;
          nxt_cur.st = ecd_pkg::ST_ISSUE;
        end
      end
      ecd_pkg::ST_ISSUE: begin
        if (exec_ready) begin
          nxt_cur.valid  = 1'b1;
          nxt_cur.op     = dec_op;
          nxt_cur.len    = dec_len;
          nxt_cur.ind    = (dec_mode == ecd_pkg::MODE_REL || dec_mode == ecd_pkg::MODE_ABS)
                           && cur_ff.b1[ecd_pkg::IND_BIT];
          // Relative forms never indexed
          nxt_cur.ea     = (dec_mode == ecd_pkg::MODE_ABS) ? abs_addr : rel_addr;
          // Indexed memory ops write register zero
          nxt_cur.dest   = (dec_indexable && idx_ctl != ecd_pkg::IDX_NONE) ? ecd_pkg::DEST_IDX_REG
                                                                           : cur_ff.opc[1:0];
          nxt_cur.idx_we  = dec_indexable && (idx_ctl == ecd_pkg::IDX_INC || idx_ctl == ecd_pkg::IDX_DEC);
          // Indexed jump and call fixed on register 3
          nxt_cur.idx_reg = is_idx_br ? ecd_pkg::JUMP_IDX_REG : cur_ff.opc[1:0];
          nxt_cur.idx_val = idx_new;
          nxt_cur.reg_we  = (dec_op == ecd_pkg::OPC_JUMP_INC) || (dec_op == ecd_pkg::OPC_JUMP_DEC);
          nxt_cur.reg_val = br_new;
          unique case (dec_op)
            ecd_pkg::OPC_JUMP_T, ecd_pkg::OPC_CALL_T, ecd_pkg::OPC_RETURN, ecd_pkg::OPC_RETURN_EI:
              nxt_cur.ctrue = (cur_ff.opc[1:0] == ecd_pkg::COND_ALWAYS)
                              || (cur_ff.opc[1:0] == cond_code);
            // Condition 3 never reaches here as a false
            ecd_pkg::OPC_JUMP_F, ecd_pkg::OPC_CALL_F:
              nxt_cur.ctrue = (cur_ff.opc[1:0] != cond_code);
            ecd_pkg::OPC_JUMP_NZ, ecd_pkg::OPC_CALL_NZ:
              nxt_cur.ctrue = (branch_reg_val != 8'h00);
            ecd_pkg::OPC_JUMP_INC, ecd_pkg::OPC_JUMP_DEC:
              nxt_cur.ctrue = (br_new != 8'h00);
            ecd_pkg::OPC_ZP_JUMP, ecd_pkg::OPC_ZP_CALL, ecd_pkg::OPC_IDX_JUMP, ecd_pkg::OPC_IDX_CALL:
              nxt_cur.ctrue = 1'b1;
            default: nxt_cur.ctrue = 1'b0;
          endcase
          if (dec_op == ecd_pkg::OPC_ZP_JUMP || dec_op == ecd_pkg::OPC_ZP_CALL) begin
            nxt_cur.ea = {2'h0, 13'(rel_addr[ecd_pkg::OFFS_MSB:0] - cur_ff.pc[ecd_pkg::OFFS_MSB:0])};
          end
          nxt_cur.halt = (dec_op == ecd_pkg::OPC_HALT);
          nxt_cur.st   = ecd_pkg::ST_IDLE;
        end
      end
    endcase
    // Only branches move to another page
    if (branch_taken) begin
      nxt_cur.pc = branch_target;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cur_ff <= '{st: ecd_pkg::ST_IDLE, pc: ecd_pkg::RESET_PC, op: ecd_pkg::OPC_NOP, default: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign fetch_addr      = cur_ff.pc;
  assign fetch_req       = !cur_ff.halt && cur_ff.st != ecd_pkg::ST_ISSUE
                           && !(cur_ff.st == ecd_pkg::ST_OPND1 && dec_len == ecd_pkg::LEN_ONE);
  assign issue_valid     = cur_ff.valid;
  assign issue_op        = cur_ff.op;
  assign issue_func      = cur_ff.opc[ecd_pkg::CLASS_MSB:ecd_pkg::CLASS_LSB];
  assign issue_reg       = cur_ff.opc[1:0];
  assign issue_dest      = cur_ff.dest;
  assign issue_len       = cur_ff.len;
  assign issue_imm       = cur_ff.b1;
  assign issue_ea        = cur_ff.ea;
  assign issue_indirect  = cur_ff.ind;
  assign issue_cond_true = cur_ff.ctrue;
  assign issue_idx_we    = cur_ff.idx_we;
  assign issue_idx_reg   = cur_ff.idx_reg;
  assign issue_idx_val   = cur_ff.idx_val;
  assign issue_reg_we    = cur_ff.reg_we;
  assign issue_reg_val   = cur_ff.reg_val;
  assign issue_undef     = cur_ff.valid && cur_ff.op == ecd_pkg::OPC_UNDEF;
  assign halted          = cur_ff.halt;

  // ********************************************************************
  // Checks
  // ********************************************************************
  sequence halt_issue_s;
    issue_valid && issue_op == ecd_pkg::OPC_HALT;
  endsequence

  halt_stops_fetch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    halt_issue_s |-> halted && !fetch_req) else $error("halt did not stop fetch");
  length_match_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue_valid && issue_op == ecd_pkg::OPC_HALT |-> issue_len == 2'h1) else $error("bad length");
  idx_dest_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue_valid && issue_idx_we |-> issue_dest == 2'h0) else $error("indexed dest not r0");
  idx_jump_reg_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue_valid && issue_op == ecd_pkg::OPC_IDX_JUMP |-> issue_idx_reg == 2'h3 && !issue_idx_we)
    else $error("indexed jump register wrong");
  loop_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue_valid && issue_reg_we |-> issue_cond_true == (issue_reg_val != 8'h00)) else $error("loop test wrong");
  zp_jump_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue_valid && issue_op == ecd_pkg::OPC_ZP_JUMP |-> issue_cond_true && issue_len == 2'h2)
    else $error("zero page jump wrong");
  pc_page_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !branch_taken |=> fetch_addr[14:13] == $past(fetch_addr[14:13])) else $error("page changed");
  undef_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue_undef |-> issue_len == 2'h1 && !issue_idx_we) else $error("undefined op not no-op");
endmodule

/* test/ecd_prog_mem.sv */
`timescale 1ns/10ps
module ecd_prog_mem (
  // Clock
  input  wire logic        ref_clk,
  // Fetch port
  input  wire logic [14:0] fetch_addr,
  input  wire logic        fetch_req,
  input  wire logic        stall,
  output logic      [7:0]  fetch_data,
  output logic             fetch_valid
);
  logic [7:0] mem [0:63];
  initial begin
    fetch_data = 8'h00;
    fetch_valid = 1'b0;
  end
  // Stall gives slow replies; idle data toggles so a stale byte never looks fresh
  always @(negedge ref_clk) begin
    fetch_valid <= fetch_req & ~stall;
    fetch_data  <= (fetch_req & ~stall) ? mem[fetch_addr[5:0]] : ~fetch_data;
  end
endmodule

/* test/ecd_tb_top.sv */
`timescale 1ns/10ps
module eight_bit_cpu_opcode_decode_addressing_tb_top;
  typedef struct {logic [5:0] op; logic [1:0] len; logic [14:0] ea; logic [7:0] aux; logic ct; logic [4:0] ck;} ecd_exp_s;
  logic ref_clk, rst_n = 1'b0, exec_ready = 1'b0, resume = 1'b0, stall = 1'b0, fetch_req, fetch_valid;
  logic [14:0] fetch_addr, issue_ea;
  logic [7:0] fetch_data, issue_idx_val, issue_reg_val;
  logic [1:0] issue_dest, issue_len, issue_idx_reg;
  logic issue_valid, issue_cond_true, issue_undef, halted;
  ecd_pkg::ecd_op_e issue_op;
  logic [23:0] r = 24'h012835;
  ecd_exp_s q[$];
  ecd_exp_s e;
  int error_cnt = 0, checks = 0, ptr = 0, cyc = 0, i;
  ecd_prog_mem pm (.ref_clk(ref_clk), .fetch_addr(fetch_addr), .fetch_req(fetch_req), .stall(stall),
    .fetch_data(fetch_data), .fetch_valid(fetch_valid));
  ecd_decode uut (.ref_clk(ref_clk), .rst_n(rst_n), .fetch_addr(fetch_addr), .fetch_req(fetch_req),
    .fetch_data(fetch_data), .fetch_valid(fetch_valid), .index_val(8'hff), .branch_reg_val(8'hff),
    .cond_code(2'h0), .exec_ready(exec_ready), .branch_taken(1'b0), .branch_target(15'h0000), .resume(resume),
    .issue_valid(issue_valid), .issue_op(issue_op), .issue_func(), .issue_reg(), .issue_dest(issue_dest),
    .issue_len(issue_len), .issue_imm(), .issue_ea(issue_ea), .issue_indirect(), .issue_cond_true(issue_cond_true),
    .issue_idx_we(), .issue_idx_reg(issue_idx_reg), .issue_idx_val(issue_idx_val), .issue_reg_we(),
    .issue_reg_val(issue_reg_val), .issue_undef(issue_undef), .halted(halted));
  function automatic logic [23:0] lfsr(input logic [23:0] s);
    return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
  endfunction
  task automatic cmp(input string n, input logic [15:0] x, input logic [15:0] s);
    checks++;
    if (s !== x) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic ins(input logic [7:0] b0, b1, b2, input int n, input ecd_pkg::ecd_op_e op,
                     input logic [14:0] ea, input logic [7:0] aux, input logic ct, input logic [4:0] ck);
    pm.mem[ptr] = b0;
    pm.mem[ptr + 1] = b1;
    pm.mem[ptr + 2] = b2;
    ptr += n;
    q.push_back('{op, n[1:0], ea, aux, ct, ck});
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Random stalls on both handshakes
  always @(negedge ref_clk) begin
    r = lfsr(r);
    exec_ready = r[0];
    stall <= r[1];
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      complete_run;
    end
  end
  always @(negedge ref_clk) if (issue_valid === 1'b1) begin
    if (q.size() == 0) cmp("extra issue", 16'h0, 16'h1);
    else begin
      e = q.pop_front();
      cmp("op", e.op, issue_op);
      cmp("len", e.len, issue_len);
      cmp("undef", e.op == ecd_pkg::OPC_UNDEF, issue_undef);
      if (e.ck[0]) cmp("ea", e.ea, issue_ea);
      if (e.ck[1]) cmp("idx", {e.aux, 8'h00}, {issue_idx_val, 6'h0, issue_dest});
      if (e.ck[2]) cmp("reg", e.aux, issue_reg_val);
      if (e.ck[3]) cmp("cond", e.ct, issue_cond_true);
      if (e.ck[4]) cmp("idx reg", 16'h3, issue_idx_reg);
    end
  end
  initial begin
    // Program never uses a false-branch with mask 3
    ins(8'h00, 8'h00, 8'h00, 1, ecd_pkg::OPC_LOAD, 0, 0, 0, 0);
    ins(8'h24, 8'h07, 8'h00, 2, ecd_pkg::OPC_XOR, 0, 0, 0, 0);
    ins(8'h1b, 8'h40, 8'h00, 2, ecd_pkg::OPC_JUMP_T, 15'h1fc5, 0, 1, 9);
    ins(8'h19, 8'h3f, 8'h00, 2, ecd_pkg::OPC_JUMP_T, 15'h0046, 0, 0, 9);
    ins(8'h0d, 8'h3f, 8'hfe, 3, ecd_pkg::OPC_LOAD, 15'h1ffe, 8'h00, 0, 3);
    ins(8'h0d, 8'h5f, 8'hff, 3, ecd_pkg::OPC_LOAD, 15'h00fd, 8'hfe, 0, 3);
    ins(8'h9f, 8'h80, 8'h10, 3, ecd_pkg::OPC_IDX_JUMP, 15'h010f, 0, 1, 17);
    ins(8'hd9, 8'h01, 8'h00, 2, ecd_pkg::OPC_JUMP_INC, 0, 8'h00, 0, 12);
    ins(8'hf9, 8'h01, 8'h00, 2, ecd_pkg::OPC_JUMP_DEC, 0, 8'hfe, 1, 12);
    ins(8'h34, 8'h00, 8'h00, 1, ecd_pkg::OPC_RETURN_EI, 0, 0, 0, 0);
    ins(8'h74, 8'h0f, 8'h00, 2, ecd_pkg::OPC_CLR_PSU, 0, 0, 0, 0);
    ins(8'hf4, 8'h0f, 8'h00, 2, ecd_pkg::OPC_MASK_TEST, 0, 0, 0, 0);
    ins(8'h10, 8'h00, 8'h00, 1, ecd_pkg::OPC_UNDEF, 0, 0, 0, 0);
    ins(8'h40, 8'h00, 8'h00, 1, ecd_pkg::OPC_HALT, 0, 0, 0, 0);
    ins(8'h9b, 8'h05, 8'h00, 2, ecd_pkg::OPC_ZP_JUMP, 15'h0005, 0, 0, 1);
    for (i = 0; i < 8; i++) ins({i[2:0], 5'h01}, 8'h00, 8'h00, 1, ecd_pkg::ecd_op_e'(i), 0, 0, 0, 0);
    ins(8'h40, 8'h00, 8'h00, 1, ecd_pkg::OPC_HALT, 0, 0, 0, 0);
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk) rst_n = 1'b1;
    for (i = 0; i < 2000 && halted !== 1'b1; i++) @(negedge ref_clk);
    repeat (3) @(negedge ref_clk) cmp("fetch halted", 16'h0, fetch_req);
    resume = 1'b1;
    @(negedge ref_clk) resume = 1'b0;
    for (i = 0; i < 2000 && (halted !== 1'b1 || q.size() != 0); i++) @(negedge ref_clk);
    cmp("queue left", 16'h0, q.size());
    cmp("halted", 16'h1, halted);
    complete_run;
  end
endmodule
